// ==== hdl/hrng_map.vh ====
// constant map and overview for the hybrid random word generator
//
// How it works
// - check source for total failure at start
// - drop words touched by post-failure raw bits
// - online test at start and while running
// - no output before start pass and seeding
// - online test examines every raw bit
// - post-processor: state update, separate output function
// - output bit rate never exceeds entropy input
// - words delivered whole, 32 bits wide
// - post-processor fed by monitored physical source
// - estimator steers adaptive raw bit compression
// - post-processor state is 351 bits, seeded
`ifndef HRNG_MAP_VH
`define HRNG_MAP_VH

// widths
`define HRNG_PP_W       351
`define HRNG_WORD_W     32
// raw sampling period in clocks
`define HRNG_RAW_DIV    8'h04
// identical raw bits in a row that mean total failure
`define HRNG_TF_RUN     8'h40
// online test window, raw bits
`define HRNG_WIN_LEN    9'h100
// tolerated count of ones per window
`define HRNG_ONES_MIN   9'h05a
`define HRNG_ONES_MAX   9'h0a6
// window centre and bias limit for the estimator
`define HRNG_ONES_MID   9'h080
`define HRNG_DEV_LIM    9'h010
// raw bits folded into one compressed bit
`define HRNG_COMP_LO    3'h2
`define HRNG_COMP_HI    3'h4
// bytes absorbed while seeding, before run begins (352 bits)
`define HRNG_SEED_BYTES 6'h2c
// entropy credit bookkeeping, bits
`define HRNG_CREDIT_MAX 9'h100
`define HRNG_WORD_COST  9'h020
`define HRNG_BYTE_GAIN  9'h008

`endif

// ==== hdl/hrng_top.v ====
// hybrid random word generator: source monitor, compressor, post-processor
`timescale 1ns/1ns
`default_nettype none
`include "hrng_map.vh"

module hrng_top #(
   parameter [7:0] RAW_DIV = `HRNG_RAW_DIV,  // clocks per raw sample
   parameter [7:0] TF_RUN  = `HRNG_TF_RUN    // failure run length
)(
   input  wire                     sys_clk_in,
   input  wire                     sys_rst_in,
   input  wire                     gen_start_in,
   input  wire                     raw_bit_in,
   input  wire                     word_ready_in,
   input  wire                     fail_clear_in,
   output wire [`HRNG_WORD_W-1:0]  word_out,
   output wire                     word_valid_out,
   output wire                     seeded_out,
   output wire                     total_fail_out,
   output wire                     defect_out
);

   // one-hot states
   localparam [4:0] ST_IDLE  = 5'h01;  // generator stopped
   localparam [4:0] ST_START = 5'h02;  // start-up tests
   localparam [4:0] ST_SEED  = 5'h04;  // seeding post-processor
   localparam [4:0] ST_RUN   = 5'h08;  // delivering words
   localparam [4:0] ST_FAIL  = 5'h10;  // blocked until restart

   reg  [4:0]             state_reg;      // control state
   reg  [4:0]             state_next;     // its next value
   reg                    sync1_reg;      // pin synchroniser stage 1
   reg                    sync2_reg;      // stage 2
   reg                    sync3_reg;      // stage 3
   reg                    raw_val_reg;    // agreed raw level
   reg  [7:0]             div_reg;        // sample divider
   reg                    last_bit_reg;   // previous raw bit
   reg  [7:0]             run_cnt_reg;    // identical-bit run length
   reg  [8:0]             win_cnt_reg;    // bits in current window
   reg  [8:0]             ones_reg;       // ones in current window
   reg  [2:0]             comp_reg;       // fold ratio from estimator
   reg  [2:0]             fold_cnt_reg;   // bits folded so far
   reg                    fold_reg;       // running fold parity
   reg  [7:0]             byte_reg;       // byte under assembly
   reg  [2:0]             byte_cnt_reg;   // bits in that byte
   reg                    byte_stb_reg;   // compressed byte ready
   reg  [7:0]             byte_val_reg;   // the finished byte
   reg  [5:0]             seed_cnt_reg;   // seed bytes absorbed
   reg  [`HRNG_PP_W-1:0]  pp_reg;         // post-processor state
   reg  [8:0]             credit_reg;     // unspent entropy bits
   reg  [`HRNG_WORD_W-1:0] word_reg;      // word held for consumer
   reg                    pend_reg;       // word held, not yet taken
   reg                    rel_reg;        // word cleared for delivery
   reg  [7:0]             hold_cnt_reg;   // raw bits seen since word
   reg                    tf_flag_reg;    // sticky total failure
   reg                    def_flag_reg;   // sticky online defect

   wire        active;      // source being sampled
   wire        raw_stb;     // one raw bit taken this cycle
   wire        raw_bit;     // that bit
   wire        tf_hit;      // total failure seen now
   wire        win_end;     // window closes now
   wire [8:0]  ones_fin;    // final ones count of window
   wire [8:0]  dev;         // distance from centre
   wire        defect_hit;  // window out of tolerance
   wire        fail_now;    // any failure this cycle
   wire        fold_done;   // compressed bit ready
   wire        comp_bit;    // the compressed bit
   wire        absorb;      // byte goes into state
   wire        gen;         // produce a word now
   wire        take;        // consumer takes the word

   // post-processor state update, nonlinear mix
   function [`HRNG_PP_W-1:0] pp_upd;
      input [`HRNG_PP_W-1:0] s;
      begin
         pp_upd = {s[349:0], s[350]}
                ^ ({s[12:0], s[350:13]} & {s[40:0], s[350:41]})
                ^ {s[98:0], s[350:99]};
      end
   endfunction

   // output function, separate from the update
   function [`HRNG_WORD_W-1:0] pp_out;
      input [`HRNG_PP_W-1:0] s;
      begin
         pp_out = s[31:0] ^ s[95:64] ^ (s[63:32] & s[127:96])
                ^ (s[350:319] | s[223:192]) ^ s[287:256];
      end
   endfunction

   // combinational decode
   assign active     = ~state_reg[0] & ~state_reg[4];
   assign raw_stb    = active & (div_reg == RAW_DIV - 8'h01);
   assign raw_bit    = raw_val_reg;
   // run of identical bits reaching the limit
   assign tf_hit     = raw_stb & (run_cnt_reg != 8'h00)
                     & (raw_bit == last_bit_reg)
                     & (run_cnt_reg == TF_RUN - 8'h01);
   assign win_end    = raw_stb & (win_cnt_reg == `HRNG_WIN_LEN - 9'h001);
   assign ones_fin   = ones_reg + {8'h00, raw_bit};
   assign dev        = (ones_fin >= `HRNG_ONES_MID) ? ones_fin - `HRNG_ONES_MID
                                                    : `HRNG_ONES_MID - ones_fin;
   assign defect_hit = win_end & ((ones_fin < `HRNG_ONES_MIN)
                     | (ones_fin > `HRNG_ONES_MAX));
   assign fail_now   = tf_hit | defect_hit;
   assign fold_done  = raw_stb & (fold_cnt_reg >= comp_reg - 3'h1);
   assign comp_bit   = fold_reg ^ raw_bit;
   assign absorb     = byte_stb_reg & (state_reg[2] | state_reg[3]);
   // a word only when enough entropy credit is banked
   assign gen        = state_reg[3] & ~pend_reg & ~byte_stb_reg & ~fail_now
                     & (credit_reg >= `HRNG_WORD_COST);
   assign take       = word_valid_out & word_ready_in;

   // outputs
   assign word_out       = word_reg;
   assign word_valid_out = rel_reg & state_reg[3];
   assign seeded_out     = state_reg[3];
   assign total_fail_out = tf_flag_reg;
   assign defect_out     = def_flag_reg;

   // next-state logic
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (gen_start_in) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            if (fail_now) begin
               state_next = ST_FAIL;
            end else if (win_end) begin
               state_next = ST_SEED;
            end
         end
         ST_SEED: begin
            if (fail_now) begin
               state_next = ST_FAIL;
            end else if (byte_stb_reg
                         && seed_cnt_reg == `HRNG_SEED_BYTES - 6'h01) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fail_now) begin
               state_next = ST_FAIL;
            end
         end
         ST_FAIL: begin
            state_next = ST_FAIL;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // dropping start always stops the generator
      if (!gen_start_in) begin
         state_next = ST_IDLE;
      end
   end

   // state register
   always @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // raw pin synchroniser, change taken when stages 2 and 3 agree
   always @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         sync1_reg   <= 1'b0;
         sync2_reg   <= 1'b0;
         sync3_reg   <= 1'b0;
         raw_val_reg <= 1'b0;
      end else begin
         sync1_reg <= raw_bit_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            raw_val_reg <= sync3_reg;
         end
      end
   end

   // sampling, total failure run and online window, every bit
   always @(posedge sys_clk_in) begin
      if (sys_rst_in || state_reg[0]) begin
         div_reg      <= 8'h00;
         last_bit_reg <= 1'b0;
         run_cnt_reg  <= 8'h00;
         win_cnt_reg  <= 9'h000;
         ones_reg     <= 9'h000;
         comp_reg     <= `HRNG_COMP_HI;
      end else begin
         div_reg <= raw_stb ? 8'h00 : div_reg + 8'h01;
         if (raw_stb) begin
            last_bit_reg <= raw_bit;
            // run restarts on any change of level
            if (run_cnt_reg != 8'h00 && raw_bit == last_bit_reg) begin
               if (run_cnt_reg != 8'hff) begin
                  run_cnt_reg <= run_cnt_reg + 8'h01;
               end
            end else begin
               run_cnt_reg <= 8'h01;
            end
            if (win_end) begin
               win_cnt_reg <= 9'h000;
               ones_reg    <= 9'h000;
               // biased window: fold more raw bits per output bit
               comp_reg    <= (dev > `HRNG_DEV_LIM) ? `HRNG_COMP_HI
                                                    : `HRNG_COMP_LO;
            end else begin
               win_cnt_reg <= win_cnt_reg + 9'h001;
               ones_reg    <= ones_fin;
            end
         end
      end
   end

   // adaptive compression and byte assembly
   always @(posedge sys_clk_in) begin
      if (sys_rst_in || state_reg[0]) begin
         fold_cnt_reg <= 3'h0;
         fold_reg     <= 1'b0;
         byte_reg     <= 8'h00;
         byte_cnt_reg <= 3'h0;
         byte_stb_reg <= 1'b0;
         byte_val_reg <= 8'h00;
      end else begin
         byte_stb_reg <= 1'b0;
         if (fold_done) begin
            fold_cnt_reg <= 3'h0;
            fold_reg     <= 1'b0;
            byte_reg     <= {byte_reg[6:0], comp_bit};
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
            if (byte_cnt_reg == 3'h7) begin
               byte_stb_reg <= 1'b1;
               byte_val_reg <= {byte_reg[6:0], comp_bit};
            end
         end else if (raw_stb) begin
            fold_cnt_reg <= fold_cnt_reg + 3'h1;
            fold_reg     <= comp_bit;
         end
      end
   end

   // post-processor state, seed count and entropy credit
   always @(posedge sys_clk_in) begin
      if (sys_rst_in || state_reg[0]) begin
         pp_reg       <= {`HRNG_PP_W{1'b0}};
         seed_cnt_reg <= 6'h00;
         credit_reg   <= 9'h000;
      end else begin
         if (absorb) begin
            // compressed entropy byte mixed into the 351-bit state
            pp_reg <= pp_upd(pp_reg ^ {343'h0, byte_val_reg});
            if (state_reg[2]) begin
               seed_cnt_reg <= seed_cnt_reg + 6'h01;
            end else if (credit_reg < `HRNG_CREDIT_MAX) begin
               credit_reg <= credit_reg + `HRNG_BYTE_GAIN;
            end
         end else if (gen) begin
            // step after each word for forward secrecy
            pp_reg     <= pp_upd(pp_reg);
            credit_reg <= credit_reg - `HRNG_WORD_COST;
         end
      end
   end

   // output word, held back until a failure could have shown up
   always @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         word_reg     <= {`HRNG_WORD_W{1'b0}};
         pend_reg     <= 1'b0;
         rel_reg      <= 1'b0;
         hold_cnt_reg <= 8'h00;
      end else if (!state_reg[3] || fail_now) begin
         pend_reg     <= 1'b0;
         rel_reg      <= 1'b0;
         hold_cnt_reg <= 8'h00;
      end else if (gen) begin
         word_reg     <= pp_out(pp_reg);
         pend_reg     <= 1'b1;
         rel_reg      <= 1'b0;
         hold_cnt_reg <= 8'h00;
      end else if (take) begin
         pend_reg <= 1'b0;
         rel_reg  <= 1'b0;
      end else if (pend_reg && !rel_reg && raw_stb) begin
         // a failed source would show a full run by now
         hold_cnt_reg <= hold_cnt_reg + 8'h01;
         if (hold_cnt_reg == TF_RUN - 8'h01) begin
            rel_reg <= 1'b1;
         end
      end
   end

   // sticky failure flags, a new event beats the clear
   always @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         tf_flag_reg  <= 1'b0;
         def_flag_reg <= 1'b0;
      end else begin
         if (tf_hit) begin
            tf_flag_reg <= 1'b1;
         end else if (fail_clear_in) begin
            tf_flag_reg <= 1'b0;
         end
         if (defect_hit) begin
            def_flag_reg <= 1'b1;
         end else if (fail_clear_in) begin
            def_flag_reg <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ==== verif/hrng_checker.sv ====
// port checker for the random word generator, bound to its top
`timescale 1ns/1ns
`default_nettype none
module hrng_checker #(
   parameter [7:0] RAW_DIV = 8'h04,  // clocks per raw sample
   parameter [7:0] TF_RUN  = 8'h40   // failure run length
)(
   input wire logic        sys_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        gen_start_in,
   input wire logic        raw_bit_in,
   input wire logic        word_ready_in,
   input wire logic        fail_clear_in,
   input wire logic [31:0] word_out,
   input wire logic        word_valid_out,
   input wire logic        seeded_out,
   input wire logic        total_fail_out,
   input wire logic        defect_out
);
   reg  [15:0] run_cnt_reg;  // cycles spent in run
   wire [15:0] first_min;    // fewest cycles before a first word
   assign first_min = {2'h0, RAW_DIV, 6'h00};
   // count cycles since run began, saturating
   always @(posedge sys_clk_in) begin
      if (sys_rst_in || !seeded_out) begin
         run_cnt_reg <= 16'h0000;
      end else if (run_cnt_reg != 16'hffff) begin
         run_cnt_reg <= run_cnt_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_valid_needs_seed:
      assert property (word_valid_out |-> seeded_out) else $error("valid outside run");
   a_fail_blocks_out:
      assert property ($rose(total_fail_out) |-> !word_valid_out && !seeded_out)
      else $error("word valid at total failure");
   a_defect_blocks:
      assert property ($rose(defect_out) |-> !word_valid_out) else $error("valid at defect");
   a_word_stands:
      assert property (word_valid_out && !word_ready_in && gen_start_in |=>
         !word_valid_out || $stable(word_out)) else $error("held word changed");
   a_no_back_to_back:
      assert property (word_valid_out && word_ready_in |=> !word_valid_out [*8])
      else $error("word follows take too soon");
   a_first_word_late:
      assert property (word_valid_out |-> run_cnt_reg >= first_min)
      else $error("first word before entropy credit");
   a_fail_sticky:
      assert property (total_fail_out && !fail_clear_in |=> total_fail_out)
      else $error("failure flag dropped");
   a_defect_sticky:
      assert property (defect_out && !fail_clear_in |=> defect_out)
      else $error("defect flag dropped");
   a_stop_idles:
      assert property (!gen_start_in |=> !seeded_out && !word_valid_out)
      else $error("output after stop");
endmodule
bind hrng_top hrng_checker #(.RAW_DIV(RAW_DIV), .TF_RUN(TF_RUN)) chk_u (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .gen_start_in(gen_start_in),
   .raw_bit_in(raw_bit_in), .word_ready_in(word_ready_in), .fail_clear_in(fail_clear_in),
   .word_out(word_out), .word_valid_out(word_valid_out), .seeded_out(seeded_out),
   .total_fail_out(total_fail_out), .defect_out(defect_out));
`default_nettype wire

// ==== verif/hrng_consumer.sv ====
// consumer model: takes words on valid, answers promptly or slowly
`timescale 1ns/1ns
`default_nettype none
module hrng_consumer (
   input  wire logic        clk_in,
   input  wire logic        valid_in,
   input  wire logic [31:0] word_in,
   input  wire logic        stall_in,
   output var  logic        ready_out,
   output var  logic [15:0] taken_out,
   output var  logic [15:0] dup_out
);
   logic [31:0] last_word;  // previous word taken
   initial begin
      ready_out = 1'b1;
      taken_out = 16'h0000;
      dup_out   = 16'h0000;
      last_word = 32'h0000_0000;
   end
   // take only while valid, then choose the next ready level
   always @(posedge clk_in) begin
      if (valid_in === 1'b1 && ready_out) begin
         taken_out = taken_out + 16'h0001;
         if (word_in === last_word) begin
            dup_out = dup_out + 16'h0001;
         end
         last_word = word_in;
      end
      #2 ready_out = stall_in ? !ready_out : 1'b1;
   end
endmodule
`default_nettype wire

// ==== verif/hybrid_random_number_generator_tb.sv ====
// self-checking bench for the random word generator
`timescale 1ns/1ns
`default_nettype none
module hybrid_random_number_generator_tb;
   typedef struct packed {
      logic [2:0] mode;   // raw pattern
      logic [2:0] flags;  // expected seeded, total failure, defect
   } hrng_row_t;
   hrng_row_t   rows [5] = '{{3'h0, 3'h4}, {3'h1, 3'h2}, {3'h2, 3'h2},
                             {3'h3, 3'h1}, {3'h4, 3'h1}};
   logic        sys_clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        gen_start  = 1'b0;
   logic        raw_bit    = 1'b0;
   logic        fail_clear = 1'b0;
   logic        stall      = 1'b0;
   logic        ready, valid, seeded, tfail, defect;
   logic [31:0] word;
   logic [15:0] taken, dups;
   logic [2:0]  mode = 3'h0;   // raw pattern in use
   logic [6:0]  lfsr = 7'h5a;  // balanced source, runs below eight
   int          div = 0, ph = 0, cyc = 0, t0, n0, err_count = 0, checked = 0;
   hrng_top #(.RAW_DIV(8'h04), .TF_RUN(8'h08)) dut_u (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .gen_start_in(gen_start), .raw_bit_in(raw_bit),
      .word_ready_in(ready), .fail_clear_in(fail_clear), .word_out(word),
      .word_valid_out(valid), .seeded_out(seeded), .total_fail_out(tfail),
      .defect_out(defect));
   hrng_consumer cons_u (.clk_in(sys_clk_in), .valid_in(valid), .word_in(word),
      .stall_in(stall), .ready_out(ready), .taken_out(taken), .dup_out(dups));
   // free-running clock
   initial begin
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   // raw source: a new bit every four clocks
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      #2;
      div = (div + 1) % 4;
      if (div == 0) begin
         lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
         ph   = (ph + 1) % 7;
         case (mode)
            3'h0: raw_bit = lfsr[0];
            3'h1: raw_bit = 1'b0;
            3'h2: raw_bit = 1'b1;
            3'h3: raw_bit = (ph != 0);
            default: raw_bit = (ph == 0);
         endcase
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #2;
   endtask
   // wait, bounded, for any flag picked by the mask
   task automatic wait_flag(input logic [2:0] mask, input int max);
      for (int i = 0; i < max && ({seeded, tfail, defect} & mask) === 3'h0; i++) tick(1);
   endtask
   // stop, clear flags, pick a pattern, start again
   task automatic restart(input logic [2:0] m);
      gen_start  = 1'b0;
      fail_clear = 1'b1;
      tick(2);
      fail_clear = 1'b0;
      mode       = m;
      tick(8);
      gen_start  = 1'b1;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog well past the expected run length
   initial begin
      #(90000 * 40);
      err_count++;
      conclude();
   end
   initial begin
      tick(6);
      sys_rst_in = 1'b0;
      for (int r = 0; r < 5; r++) begin
         restart(rows[r].mode);
         wait_flag(3'h7, 6000);
         tick(40);
         chk({29'h0, seeded, tfail, defect}, {29'h0, rows[r].flags});
         $display("row %0d done", r);
      end
      restart(3'h0);
      stall = 1'b1;
      wait_flag(3'h4, 6000);
      t0 = cyc;
      n0 = taken;
      tick(3000);
      chk(32'(taken - n0 > 0), 32'h1);
      chk(32'((taken - n0) * 256 <= cyc - t0 + 8), 32'h1);
      chk({16'h0, dups}, 32'h0);
      $display("test stalled rate done");
      stall = 1'b0;
      mode  = 3'h2;
      wait_flag(3'h2, 400);
      n0 = taken;
      tick(300);
      chk(32'(taken), 32'(n0));
      chk({29'h0, seeded, valid, tfail}, 32'h1);
      $display("test running failure done");
      restart(3'h0);
      wait_flag(3'h4, 6000);
      mode = 3'h3;
      wait_flag(3'h1, 2600);
      tick(2);
      chk({29'h0, seeded, valid, defect}, 32'h1);
      gen_start = 1'b0;
      tick(4);
      chk({31'h0, defect}, 32'h1);
      fail_clear = 1'b1;
      tick(1);
      fail_clear = 1'b0;
      tick(1);
      chk({31'h0, defect}, 32'h0);
      $display("test running defect done");
      restart(3'h0);
      wait_flag(3'h4, 6000);
      tick(300);
      sys_rst_in = 1'b1;
      tick(2);
      chk({28'h0, seeded, valid, tfail, defect}, 32'h0);
      chk(word, 32'h0);
      sys_rst_in = 1'b0;
      // first two edges after release: restarting, nothing shown yet
      tick(2);
      chk({28'h0, seeded, valid, tfail, defect}, 32'h0);
      // start still high, so the generator must seed again from scratch
      wait_flag(3'h4, 6000);
      chk({29'h0, seeded, tfail, defect}, 32'h4);
      $display("test mid-run reset done");
      conclude();
   end
endmodule
`default_nettype wire
